// ===== rtl/fpio_front_panel.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module fpio_front_panel
  import fpio_pkg::*;
#(
  parameter int unsigned INTEG_60_CYC = CLK_HZ / LINE_60_HZ,
  parameter int unsigned INTEG_50_CYC = CLK_HZ / LINE_50_HZ
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] key_drive_lines,
  input wire logic [3:0] key_return_lines,
  output logic display_write_enable,
  output logic disp_data,
  output logic disp_clk1,
  output logic disp_clk2,
  output logic display_instruction_line,
  output logic disp_sync,
  input wire logic [7:0] config_switch_data,
  output logic switch_buffer_read_enable_b,
  output logic switch_buffer_select_b,
  output logic [4:0] bus_address_switches,
  output logic talk_only,
  output logic powerup_request_switch,
  output logic line_freq_50,
  output logic [INTEG_W-1:0] integ_period_cycles,
  output logic meas_complete_b,
  input wire logic ext_trigger,
  output logic trigger_flag,
  output logic meas_start,
  output logic bus_trigger_pulse
);
  localparam int MC_LEN = MEAS_PULSE_CYC;
  localparam logic [7:0] STEP_LAST = 8'(SCAN_STEP_CYC - 1);
  localparam logic [7:0] MC_LAST = 8'(MEAS_PULSE_CYC - 1);

  // AXI4-Lite slave: address and data may arrive in either order
  logic aw_got_ff, w_got_ff, bvalid_ff, rd_pend_ff, rvalid_ff;
  logic [7:0] awaddr_ff, araddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_go, wr_hit;
  logic [3:0] ctrl_ff;
  fpio_disp_s disp_ff;
  logic dclk2_ff;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_hit = awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_DISP || awaddr_ff == ADDR_DCLK2
    || awaddr_ff == ADDR_BUS_TRIGGER_PULSE || awaddr_ff == ADDR_MEAS || awaddr_ff == ADDR_KEY
    || awaddr_ff == ADDR_SWITCH;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // All fields sit in byte lane 0, so only that strobe matters
  logic wr_ctrl, wr_disp, wr_dclk2, wr_bus_trigger_pulse, wr_meas;
  assign wr_ctrl = wr_go && wstrb0_ff && awaddr_ff == ADDR_CTRL;
  assign wr_disp = wr_go && wstrb0_ff && awaddr_ff == ADDR_DISP;
  assign wr_dclk2 = wr_go && wstrb0_ff && awaddr_ff == ADDR_DCLK2;
  assign wr_bus_trigger_pulse = wr_go && wstrb0_ff && awaddr_ff == ADDR_BUS_TRIGGER_PULSE && wdata_ff[0];
  assign wr_meas = wr_go && wstrb0_ff && awaddr_ff == ADDR_MEAS && wdata_ff[0];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_ff <= CTRL_RESET;
      disp_ff <= '0;
      dclk2_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= wdata_ff[3:0];
      if (wr_disp)
        disp_ff <= wdata_ff[3:0];
      if (wr_dclk2)
        dclk2_ff <= wdata_ff[0];
    end
  end

  // Display lines held quiet while display write enable is low
  assign display_write_enable = ctrl_ff[CTRL_DWE_BIT];
  assign disp_data = disp_ff.data & display_write_enable;
  assign disp_clk1 = disp_ff.clk1 & display_write_enable;
  assign disp_clk2 = dclk2_ff & display_write_enable;
  assign display_instruction_line = disp_ff.instr & display_write_enable;
  assign disp_sync = disp_ff.sync & display_write_enable;
  assign switch_buffer_select_b = ctrl_ff[CTRL_SEL_B_BIT];

  // Keypad scanner with two-stage return synchroniser
  logic [3:0] ret_s1_ff, ret_s2_ff;
  fpio_scan_e scan_ff;
  logic [7:0] step_ff;
  logic [1:0] row_ff;
  logic [3:0] drive_ff;
  fpio_key_s hit_ff, prev_ff, key_ff, nxt_hit;
  logic step_end, scan_end;
  logic [1:0] ret_idx;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ret_s1_ff <= 4'h0;
      ret_s2_ff <= 4'h0;
    end
    else
    begin
      ret_s1_ff <= key_return_lines;
      ret_s2_ff <= ret_s1_ff;
    end
  end

  // Lowest return line wins when several are high
  always_comb
  begin
    ret_idx = 2'd0;
    for (int i = 3; i >= 0; i--)
      if (ret_s2_ff[i])
        ret_idx = 2'(i);
  end

  // Each step lasts long enough for the two sync stages to settle
  assign step_end = step_ff == STEP_LAST;
  assign scan_end = scan_ff == SCAN_DRIVE && step_end && row_ff == 2'd3;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_ff <= SCAN_IDLE;
      step_ff <= 8'h00;
      row_ff <= 2'd0;
      drive_ff <= 4'h0;
    end
    else
    begin
      step_ff <= step_end ? 8'h00 : step_ff + 8'h01;
      unique case (scan_ff)
        SCAN_IDLE:
          if (step_end && ctrl_ff[CTRL_SCAN_BIT])
          begin
            scan_ff <= SCAN_DRIVE;
            row_ff <= 2'd0;
            drive_ff <= 4'h1;
          end
        SCAN_DRIVE:
          if (step_end)
          begin
            if (row_ff == 2'd3)
            begin
              scan_ff <= SCAN_IDLE;
              drive_ff <= 4'h0;
            end
            else
            begin
              row_ff <= row_ff + 2'd1;
              drive_ff <= {drive_ff[2:0], 1'b0};
            end
          end
      endcase
    end
  end
  assign key_drive_lines = drive_ff;

  // The last row's hit lands on the scan-end edge, so compare the next value, not the register
  always_comb
  begin
    nxt_hit = hit_ff;
    if (!hit_ff.valid && ret_s2_ff != 4'h0)
      nxt_hit = '{valid: 1'b1, drive: row_ff, ret: ret_idx};
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hit_ff <= '0;
      prev_ff <= '0;
      key_ff <= '0;
    end
    else if (scan_ff == SCAN_IDLE && step_end)
      hit_ff <= '0;
    else if (scan_ff == SCAN_DRIVE && step_end)
    begin
      hit_ff <= nxt_hit;
      if (scan_end)
      begin
        prev_ff <= nxt_hit;
        if (nxt_hit == prev_ff)
          key_ff <= nxt_hit;
      end
    end
  end

  // Switch buffer: reads take two cycles so the enable is seen before sampling
  logic rd_sw;
  assign s_axi_arready = !rd_pend_ff && !rvalid_ff;
  assign rd_sw = rd_pend_ff && araddr_ff == ADDR_SWITCH;
  assign switch_buffer_read_enable_b = !rd_sw;

  logic sw_en;
  logic [7:0] sw_ff;
  assign sw_en = !switch_buffer_read_enable_b && !switch_buffer_select_b;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sw_ff <= 8'hFF;
    else if (sw_en)
      sw_ff <= config_switch_data;
  end

  // Closed position reads low, so a closed address switch is a one bit
  assign talk_only = sw_ff[4:0] == 5'h00;
  assign bus_address_switches = talk_only ? 5'h00 : ~sw_ff[4:0];
  assign powerup_request_switch = !sw_ff[SW_SRQ_BIT];
  assign line_freq_50 = !sw_ff[SW_FREQ_BIT];
  assign integ_period_cycles = line_freq_50 ? INTEG_W'(INTEG_50_CYC)
    : INTEG_W'(INTEG_60_CYC);

  // Trigger: sync, edge detect, pending flag, start pulse
  logic [2:0] trg_sync_ff;
  logic trg_edge, bus_trigger_pulse_flag_ff, start_ff;
  logic ext_mode;
  assign ext_mode = ctrl_ff[CTRL_EXT_BIT];
  assign trg_edge = trg_sync_ff[1] && !trg_sync_ff[2];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      trg_sync_ff <= 3'b000;
    else
      trg_sync_ff <= {trg_sync_ff[1:0], ext_trigger};
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_trigger_pulse_flag_ff <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      // A new edge beats the re-arm clear
      if (trg_edge)
        bus_trigger_pulse_flag_ff <= 1'b1;
      else if (start_ff || wr_bus_trigger_pulse)
        bus_trigger_pulse_flag_ff <= 1'b0;
      start_ff <= ext_mode && bus_trigger_pulse_flag_ff && !start_ff;
    end
  end
  assign trigger_flag = bus_trigger_pulse_flag_ff;
  assign meas_start = start_ff;
  assign bus_trigger_pulse = start_ff;

  // Measurement complete pulse from the program strobe
  logic mc_act_ff;
  logic [7:0] mc_cnt_ff;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mc_act_ff <= 1'b0;
      mc_cnt_ff <= 8'h00;
    end
    else if (wr_meas && !mc_act_ff)
    begin
      mc_act_ff <= 1'b1;
      mc_cnt_ff <= 8'h00;
    end
    else if (mc_act_ff)
    begin
      mc_cnt_ff <= mc_cnt_ff + 8'h01;
      if (mc_cnt_ff == MC_LAST)
        mc_act_ff <= 1'b0;
    end
  end
  assign meas_complete_b = !mc_act_ff;

  // Read data path
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pend_ff <= 1'b0;
      araddr_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rd_pend_ff <= 1'b1;
      araddr_ff <= s_axi_araddr;
    end
    else if (rd_pend_ff)
    begin
      rd_pend_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      unique case (araddr_ff)
        ADDR_CTRL: rdata_ff <= {28'h000_0000, ctrl_ff};
        ADDR_KEY: rdata_ff <= {27'h000_0000, key_ff};
        ADDR_SWITCH: rdata_ff <= {24'h00_0000, sw_en ? config_switch_data : 8'hFF};
        ADDR_DISP: rdata_ff <= {28'h000_0000, disp_ff};
        ADDR_DCLK2: rdata_ff <= {31'h0000_0000, dclk2_ff};
        ADDR_BUS_TRIGGER_PULSE: rdata_ff <= {31'h0000_0000, bus_trigger_pulse_flag_ff};
        ADDR_MEAS: rdata_ff <= {31'h0000_0000, mc_act_ff};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  a_drive_one_hot: assert property (@(posedge clock) disable iff (!rst_b)
    $onehot0(key_drive_lines)) else $error("more than one key drive line high");
  a_idle_all_low: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(scan_ff == SCAN_DRIVE) |-> $past(key_drive_lines) == 4'h0 && key_drive_lines == 4'h1)
    else $error("scan did not start from all low on first drive line");
  a_key_on_scan: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(key_ff) |-> $past(scan_end) && $past(nxt_hit) == $past(prev_ff))
    else $error("key report changed without two agreeing scans");
  a_disp_gated: assert property (@(posedge clock) disable iff (!rst_b)
    !display_write_enable |-> !disp_data && !disp_clk1 && !disp_clk2 && !disp_sync
    && !display_instruction_line)
    else $error("display lines active with write enable low");
  a_sw_window: assert property (@(posedge clock) disable iff (!rst_b)
    sw_en |-> rd_pend_ff && araddr_ff == ADDR_SWITCH && !switch_buffer_select_b)
    else $error("switch buffer enabled outside a switch read");
  a_talk_only_sel: assert property (@(posedge clock) disable iff (!rst_b)
    talk_only |-> bus_address_switches == 5'h00 && sw_ff[4:0] == 5'h00)
    else $error("talk-only decode wrong");
  a_mc_width: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(meas_complete_b) |-> ##(MC_LEN) $rose(meas_complete_b))
    else $error("measurement complete pulse width wrong");
  a_bus_trigger_pulse_set: assert property (@(posedge clock) disable iff (!rst_b)
    trg_edge |=> trigger_flag) else $error("trigger edge did not set flag");
  a_bus_trigger_pulse_hold: assert property (@(posedge clock) disable iff (!rst_b)
    trigger_flag && !ext_mode && !wr_bus_trigger_pulse && !start_ff |=> trigger_flag)
    else $error("trigger flag cleared outside external mode");
  a_bus_trigger_pulse_rearm: assert property (@(posedge clock) disable iff (!rst_b)
    ext_mode && trigger_flag && !start_ff |=> bus_trigger_pulse ##1 (trigger_flag == $past(trg_edge)))
    else $error("trigger start or re-arm wrong");

  c_key_seen: cover property (@(posedge clock) disable iff (!rst_b) $rose(key_ff.valid));
  c_bus_trigger_pulse_run: cover property (@(posedge clock) disable iff (!rst_b) bus_trigger_pulse);
  c_mc_pulse: cover property (@(posedge clock) disable iff (!rst_b) $rose(meas_complete_b));
  c_sw_read: cover property (@(posedge clock) disable iff (!rst_b) sw_en);
endmodule : fpio_front_panel

// ===== rtl/fpio_pkg.sv
// What this block does
// - Scan the four-by-four key matrix continuously while running.
// - Four drive lines are outputs; four return lines are sampled inputs.
// - Drive lines all low before a scan, then raised high in turn from first.
// - Pressed key is the high drive line paired with a high return line.
// - Serial display data may shift only while display write enable is high.
// - Display gets two clocks: one from the latch, one direct port.
// - Data, first clock, instruction and sync come from a latch updated per bus write.
// - Drive a display instruction line and a sync line marking instruction sampling.
// - Read configuration switch only when read strobe and latched select are low.
// - Five positions form bus address; all five closed selects talk-only.
// - One position sets power-on service request, forwarded to bus logic.
// - One position picks line frequency; integration time 1/60 s or 1/50 s.
// - Measurement complete is a negative pulse near 1 us from program strobe.
// - External trigger edge sets trigger-pending flag shown to controller.
// - Outside external trigger mode a set flag does nothing and stays set until a bus write of bit 0 to its register clears it.
// - In external mode a set flag starts measurement; mode change stops polling.
// - Measurement start emits trigger pulse that clears flag, re-arming it.
package fpio_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MEAS_PULSE_NS = 1000;
  localparam int unsigned MEAS_PULSE_CYC = (MEAS_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SCAN_STEP_NS = 1000;
  localparam int unsigned SCAN_STEP_CYC = (SCAN_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LINE_60_HZ = 60;
  localparam int unsigned LINE_50_HZ = 50;
  localparam int unsigned INTEG_W = 22;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEY = 8'h04;
  localparam logic [7:0] ADDR_SWITCH = 8'h08;
  localparam logic [7:0] ADDR_DISP = 8'h0C;
  localparam logic [7:0] ADDR_DCLK2 = 8'h10;
  localparam logic [7:0] ADDR_BUS_TRIGGER_PULSE = 8'h14;
  localparam logic [7:0] ADDR_MEAS = 8'h18;
  localparam int unsigned CTRL_DWE_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT = 1;
  localparam int unsigned CTRL_SEL_B_BIT = 2;
  localparam int unsigned CTRL_SCAN_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'hC;
  localparam int unsigned SW_SRQ_BIT = 5;
  localparam int unsigned SW_FREQ_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {SCAN_IDLE = 2'b01, SCAN_DRIVE = 2'b10} fpio_scan_e;
  typedef struct packed {
    logic valid;
    logic [1:0] drive;
    logic [1:0] ret;
  } fpio_key_s;
  typedef struct packed {
    logic sync;
    logic instr;
    logic clk1;
    logic data;
  } fpio_disp_s;
endpackage : fpio_pkg

// ===== verification/fpio_panel_model.sv
`timescale 1ns/100ps
module fpio_panel_model
  import fpio_pkg::*;
(
  input wire logic [3:0] key_drive_lines,
  output logic [3:0] key_return_lines,
  input wire logic key_down,
  input wire logic [1:0] key_row,
  input wire logic [1:0] key_col,
  input wire logic [7:0] switch_closed_b,
  input wire logic switch_buffer_read_enable_b,
  input wire logic switch_buffer_select_b,
  output logic [7:0] config_switch_data
);
  // A pressed key conducts only while its own drive line is high
  always_comb
  begin
    key_return_lines = 4'h0;
    if (key_down && key_drive_lines[key_row])
    begin
      key_return_lines[key_col] = 1'h1;
    end
  end
  // Buffer off means a floating bus: show the inverse so a stale read cannot match
  assign config_switch_data = (!switch_buffer_read_enable_b && !switch_buffer_select_b) ?
    switch_closed_b : ~switch_closed_b;
endmodule : fpio_panel_model

// ===== verification/front_panel_io_controller_bench.sv
`timescale 1ns/100ps
module front_panel_io_controller_bench
  import fpio_pkg::*;
;
  localparam int unsigned I60 = 60;
  localparam int unsigned I50 = 50;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] drive, ret;
  logic dwe, dd, dc1, dc2, di, ds, re_b, sel_b, talk, srq, f50, mc_b, flag, mstart, tpulse;
  logic [4:0] baddr;
  logic [INTEG_W-1:0] integ;
  logic [7:0] sw_data;
  logic [7:0] sw_val = 8'hff;
  logic key_down = 1'h0;
  logic [1:0] key_row = 2'h0;
  logic [1:0] key_col = 2'h0;
  logic ext_trigger = 1'h0;
  int failures = 0;
  int checks_done = 0;
  int pulses = 0;

  always #2.5 clock = ~clock;

  fpio_front_panel #(.INTEG_60_CYC(I60), .INTEG_50_CYC(I50)) u_dut (
    .clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_drive_lines(drive), .key_return_lines(ret), .display_write_enable(dwe),
    .disp_data(dd), .disp_clk1(dc1), .disp_clk2(dc2), .display_instruction_line(di),
    .disp_sync(ds), .config_switch_data(sw_data), .switch_buffer_read_enable_b(re_b),
    .switch_buffer_select_b(sel_b), .bus_address_switches(baddr), .talk_only(talk),
    .powerup_request_switch(srq), .line_freq_50(f50), .integ_period_cycles(integ),
    .meas_complete_b(mc_b), .ext_trigger(ext_trigger), .trigger_flag(flag),
    .meas_start(mstart), .bus_trigger_pulse(tpulse));

  fpio_panel_model u_panel (
    .key_drive_lines(drive), .key_return_lines(ret), .key_down(key_down),
    .key_row(key_row), .key_col(key_col), .switch_closed_b(sw_val),
    .switch_buffer_read_enable_b(re_b), .switch_buffer_select_b(sel_b),
    .config_switch_data(sw_data));

  // Both pulses must coincide, so a missing one shows up as a short count
  always @(posedge clock)
  begin
    if (tpulse === 1'h1 && mstart === 1'h1)
      pulses <= pulses + 1;
  end

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic stop_hung(input string what);
    failures++;
    $display("Error t=%0t timeout %s", $time, what);
    print_verdict;
  endtask : stop_hung

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    r = 2'h3;
    for (n = 0; n < 1000; n++)
    begin
      @(posedge clock);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
      begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
    if (n == 1000)
      stop_hung("write");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 1000; n++)
    begin
      @(posedge clock);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
    if (n == 1000)
      stop_hung("read");
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [3:0] v);
    logic [1:0] r;
    axi_write(a, 32'(v), r);
    check_val(32'(r), 32'(RESP_OKAY), "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
    check_val(32'(r), 32'(RESP_OKAY), "rresp");
  endtask : rd

  task automatic wait_drive(input logic zero);
    int n;
    for (n = 0; n < 2000; n++)
    begin
      @(posedge clock);
      if ((drive == 4'h0) == zero)
        break;
    end
    if (n == 2000)
      stop_hung("scan");
  endtask : wait_drive

  task automatic poll_key(input logic want, output logic [31:0] d);
    int n;
    for (n = 0; n < 60; n++)
    begin
      repeat (100) @(posedge clock);
      rd(ADDR_KEY, d);
      if (d[4] === want)
        break;
    end
    if (n == 60)
      stop_hung("key");
  endtask : poll_key

  task automatic pulse_bus_trigger_pulse;
    @(posedge clock);
    ext_trigger <= 1'h1;
    repeat (2) @(posedge clock);
    ext_trigger <= 1'h0;
    repeat (12) @(posedge clock);
  endtask : pulse_bus_trigger_pulse

  function automatic logic [7:0] exp_sw(input logic [7:0] s);
    logic t;
    t = (s[4:0] == 5'h00);
    return {t ? 5'h00 : ~s[4:0], t, ~s[5], ~s[6]};
  endfunction : exp_sw

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] s;
    logic [3:0] v;
    int n;
    int p;
    void'($urandom(60004));
    repeat (5) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    check_val(32'({dwe, sel_b, re_b, mc_b, flag, drive}), 32'h0000_00e0, "reset pins");
    rd(ADDR_CTRL, d);
    check_val(d, 32'(CTRL_RESET), "ctrl reset");
    axi_read(8'h1c, d, r);
    check_val({d[29:0], r}, 32'(RESP_SLVERR), "unmapped read");
    axi_write(8'h1c, 32'h0000_000f, r);
    check_val(32'(r), 32'(RESP_SLVERR), "unmapped write");
    $display("test reset done");
    for (n = 0; n < 6; n++)
    begin
      v = (n == 0) ? 4'hf : 4'($urandom);
      p = (n == 1) ? 0 : 1;
      wr(ADDR_CTRL, 4'hc | 4'(p));
      wr(ADDR_DISP, v);
      wr(ADDR_DCLK2, {3'h0, ~v[2]});
      @(posedge clock);
      check_val(32'({ds, di, dc1, dd}), 32'(p ? v : 4'h0), "display");
      check_val(32'(dc2), 32'(p[0] & ~v[2]), "second clock");
    end
    $display("test display done");
    wr(ADDR_CTRL, 4'h8);
    for (n = 0; n < 8; n++)
    begin
      s = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : (n == 2) ? 8'he0 : 8'($urandom);
      sw_val <= s;
      rd(ADDR_SWITCH, d);
      @(posedge clock);
      check_val(d, 32'(s), "switch");
      check_val(32'({baddr, talk, srq, f50}), 32'(exp_sw(s)), "switch pins");
      check_val(32'(integ), s[6] ? I60 : I50, "integration");
    end
    wr(ADDR_CTRL, 4'hc);
    rd(ADDR_SWITCH, d);
    check_val(d, 32'h0000_00ff, "switch unselected");
    $display("test switch done");
    wait_drive(1'h1);
    wait_drive(1'h0);
    check_val(32'(drive), 32'h0000_0001, "first drive");
    for (n = 0; n < 5; n++)
    begin
      v = (n == 0) ? 4'hf : 4'($urandom);
      key_row <= v[3:2];
      key_col <= v[1:0];
      key_down <= 1'h1;
      poll_key(1'h1, d);
      check_val(d, 32'({1'h1, v}), "key");
      key_down <= 1'h0;
      poll_key(1'h0, d);
      check_val(d, 32'h0000_0000, "no key");
    end
    // A press held 300 cycles, past row 0's step-end sample but gone by the next scan, must never be reported
    key_row <= 2'h0;
    wait_drive(1'h1);
    wait_drive(1'h0);
    key_down <= 1'h1;
    repeat (300) @(posedge clock);
    key_down <= 1'h0;
    p = 0;
    for (n = 0; n < 30; n++)
    begin
      rd(ADDR_KEY, d);
      p = (d[4] === 1'h0) ? p : 1;
      repeat (100) @(posedge clock);
    end
    check_val(32'(p), 32'h0000_0000, "bounce");
    $display("test keypad done");
    p = pulses;
    pulse_bus_trigger_pulse;
    repeat (50) @(posedge clock);
    check_val(32'({flag, 8'(pulses - p)}), 32'h0000_0100, "idle mode");
    wr(ADDR_CTRL, 4'he);
    repeat (10) @(posedge clock);
    check_val(32'({flag, 8'(pulses - p)}), 32'h0000_0001, "ext start");
    pulse_bus_trigger_pulse;
    check_val(32'({flag, 8'(pulses - p)}), 32'h0000_0002, "rearm");
    $display("test trigger done");
    wr(ADDR_MEAS, 4'h1);
    p = 0;
    // The pulse is already low at the edge that returns the write response
    for (n = 0; n < 1000; n++)
    begin
      if (mc_b === 1'h0)
        p++;
      else if (p > 0)
        break;
      @(posedge clock);
    end
    check_val(32'(p), MEAS_PULSE_CYC, "pulse width");
    $display("test measure done");
    print_verdict;
  end
endmodule : front_panel_io_controller_bench
